// [design/cgi_link_if.sv]
`timescale 1ns/1ps
// Two-wire link; open-drain levels resolved from the enables
interface cgi_link_if;
   logic scl_m_oe; // Master pulls clock low
   logic sda_m_oe; // Master pulls data low
   logic sda_s_oe; // Slave pulls data low
   logic scl;
   logic sda;
   assign scl = ~scl_m_oe;
   assign sda = ~(sda_m_oe | sda_s_oe);
   modport slave (input scl, input sda, output sda_s_oe);
   modport master (input scl, input sda, output scl_m_oe, output sda_m_oe);
endinterface : cgi_link_if

// [design/cgi_map.svh]
`ifndef CGI_MAP_SVH
`define CGI_MAP_SVH
// Own bus address
`define CGI_SLAVE_ID 7'h69
// Half bit period in system cycles: 400 kHz at 100 MHz
`define CGI_HALF_CYC 125
// Memory default
`define CGI_CFG_RESET 8'h00
// Pointer reset value
`define CGI_PTR_RESET 8'h00
// Clock outputs under pin control
`define CGI_NUM_OUT 8
`endif

// [design/cgi_master.sv]
`timescale 1ns/1ps
`include "cgi_map.svh"
module cgi_master
   import cgi_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   cgi_link_if.master link,
   input wire logic cmd_valid,
   input wire cgi_op_type cmd_op,
   input wire logic [7:0] cmd_loc,
   input wire logic [7:0] cmd_data,
   input wire logic [7:0] cmd_len,
   output logic cmd_ready,
   output logic rd_valid,
   output logic [7:0] rd_data,
   output logic nack_err
);
   import cgi_pkg::*;
   localparam int HALF = `CGI_HALF_CYC; // RL4
   // ------------------------------------------------------------
   // Sequencer state
   // ------------------------------------------------------------
   logic [7:0] tick_cnt;
   logic [1:0] sda_m; // Synchronised data pin
   logic [3:0] phase; // 1 byte, 2 restart, 3 stop, 5 and 4 bus free
   logic [3:0] bitn;
   logic half_lo; // Set once the start hold half has passed
   logic scl_lo, sda_lo, rd_mode;
   logic [1:0] step;
   cgi_op_type op;
   logic [7:0] tx, rx, dat, loc, left;
   wire tick = (tick_cnt == 8'(HALF - 1));
   // Data set mid-way through the low half
   wire mid = (tick_cnt == 8'(HALF / 2 - 1));
   assign link.scl_m_oe = scl_lo;
   assign link.sda_m_oe = sda_lo;
   // ------------------------------------------------------------
   // Sync data pin
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sda_m <= 2'b11;
      end else begin
         sda_m <= {sda_m[0], link.sda};
      end
   end
   // ------------------------------------------------------------
   // Sequencer: every tick is a half bit period
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cmd_ready <= 1'b1;
         {scl_lo, sda_lo, half_lo, rd_valid, nack_err, rd_mode} <= '0;
         {tick_cnt, tx, rx, rd_data, left, dat, loc} <= '0;
         {phase, bitn, step} <= '0;
         op <= CGI_OP_WRITE;
      end else begin
         rd_valid <= 1'b0;
         tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
         if (cmd_ready) begin
            if (cmd_valid) begin
               cmd_ready <= 1'b0;
               nack_err <= 1'b0;
               op <= cmd_op;
               loc <= cmd_loc;
               dat <= cmd_data;
               left <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
               rd_mode <= (cmd_op == CGI_OP_READ_CUR);
               tx <= {`CGI_SLAVE_ID, cmd_op == CGI_OP_READ_CUR}; // RL2 RL12
               sda_lo <= 1'b1; // RL6
               phase <= 4'd1;
               bitn <= 4'd0;
               half_lo <= 1'b0;
               step <= 2'd0;
               tick_cnt <= 8'h00;
            end
         end else if (mid && phase == 4'd1 && half_lo && scl_lo) begin
            // Clock low: next bit, ack or release
            if (bitn < 4'd8) begin
               sda_lo <= rd_mode && step != 2'd0 ? 1'b0 : ~tx[3'd7 - bitn[2:0]]; // RL5
            end else begin
               // Ack all but the last read byte
               sda_lo <= rd_mode && step != 2'd0 && left != 8'h01; // RL9
            end
         end else if (tick) begin
            unique case (phase)
               4'd1: begin
                  // Byte phase: low half drives, high half samples
                  if (!half_lo) begin
                     scl_lo <= 1'b1;
                     half_lo <= 1'b1;
                  end else if (!scl_lo) begin
                     // Clock high finished: sample
                     if (bitn == 4'd8) begin
                        bitn <= 4'd0;
                        if (rd_mode && step != 2'd0) begin
                           rd_valid <= 1'b1;
                           rd_data <= rx;
                           left <= left - 8'h01;
                           if (left == 8'h01) begin
                              phase <= 4'd3;
                           end
                        end else if (sda_m[1]) begin
                           nack_err <= 1'b1;
                           phase <= 4'd3;
                        end else begin
                           // Saturates so a long burst never reopens the location byte
                           step <= (step == 2'd3) ? step : step + 2'd1;
                           if (rd_mode) begin
                              step <= 2'd1;
                           end else if (step == 2'd0) begin
                              tx <= loc; // RL3
                           end else if (op == CGI_OP_SET_PTR) begin
                              phase <= 4'd3;
                           end else if (op == CGI_OP_READ_RND) begin
                              phase <= 4'd2; // RL15
                           end else begin
                              tx <= dat;
                              if (step != 2'd1) begin
                                 left <= left - 8'h01;
                                 dat <= dat + 8'h01;
                                 tx <= dat + 8'h01;
                                 if (left == 8'h01) begin
                                    phase <= 4'd3; // RL10
                                 end
                              end
                           end
                        end
                     end else begin
                        rx <= {rx[6:0], sda_m[1]};
                        bitn <= bitn + 4'd1;
                     end
                     scl_lo <= 1'b1;
                  end else begin
                     // Clock low with data set: raise clock
                     scl_lo <= 1'b0;
                  end
               end
               4'd2: begin
                  // Repeated start: release data, raise clock, drop data
                  if (sda_lo) begin
                     sda_lo <= 1'b0;
                  end else if (scl_lo) begin
                     scl_lo <= 1'b0;
                  end else begin
                     sda_lo <= 1'b1; // RL6
                     rd_mode <= 1'b1;
                     step <= 2'd0;
                     tx <= {`CGI_SLAVE_ID, 1'b1};
                     half_lo <= 1'b0;
                     phase <= 4'd1;
                  end
               end
               4'd3: begin
                  // Stop: data low, clock high, then release data
                  if (!sda_lo && scl_lo) begin
                     sda_lo <= 1'b1;
                  end else if (scl_lo) begin
                     scl_lo <= 1'b0;
                  end else begin
                     sda_lo <= 1'b0; // RL7
                     phase <= 4'd5;
                  end
               end
               4'd5: begin
                  phase <= 4'd4;
               end
               default: begin
                  // Two idle halves of bus free time before the next start
                  phase <= 4'd0;
                  cmd_ready <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule : cgi_master

// [design/cgi_pkg.sv]
package cgi_pkg;
   // ------------------------------------------------------------
   // Slave phases
   // ------------------------------------------------------------
   typedef enum logic [5:0] {
      CGI_IDLE = 6'b00_0001,
      CGI_DEVA = 6'b00_0010,
      CGI_MLOC = 6'b00_0100,
      CGI_WDAT = 6'b00_1000,
      CGI_RDAT = 6'b01_0000,
      CGI_SKIP = 6'b10_0000
   } cgi_slv_state_type;
   // Master command kinds
   typedef enum logic [1:0] {
      CGI_OP_WRITE = 2'b00,
      CGI_OP_SET_PTR = 2'b01,
      CGI_OP_READ_CUR = 2'b10,
      CGI_OP_READ_RND = 2'b11
   } cgi_op_type;
endpackage : cgi_pkg

// [design/cgi_slave.sv]
`timescale 1ns/1ps
//
// Behaviour
// RL1 - Answer only bus address 69H
// RL2 - First byte: address then direction LSB
// RL3 - Write: address, location, data bytes, acks
// RL4 - Works up to 400 kbit/s
// RL5 - Data stable while clock high
// RL6 - Data falling, clock high: start
// RL7 - Data rising, clock high: stop
// RL8 - Slave acks each written byte
// RL9 - Master acks read bytes
// RL10 - Master stops after single write
// RL11 - Burst write increments location
// RL12 - Read has direction bit high
// RL13 - Pointer holds last access plus one
// RL14 - Read: ack, then shift byte out
// RL15 - Random read loads pointer only
// RL16 - Master ack advances pointer, next byte
// RL17 - Pointer wraps FFH to 00H
// RL18 - Defaults at power-up, volatile contents
// RL19 - Pin is power-down or output enable
// RL20 - Disabled outputs driven low first
// RL21 - Per-output enable-pin sensitivity
// RL22 - Keep-alive retains registers in power-down
// RL23 - Foreign address: release, ignore frame
// RL24 - 256 locations of eight bits
//
`include "cgi_map.svh"
module cgi_slave
   import cgi_pkg::*;
#(
   parameter int DEPTH = 256,
   parameter int NOUT = `CGI_NUM_OUT
) (
   input wire logic clk_sys,
   input wire logic srst,
   cgi_link_if.slave link,
   input wire logic powerdown_or_enable_pin,
   input wire logic pin_mode_oe,
   input wire logic keep_alive,
   input wire logic [NOUT-1:0] oe_sensitive,
   input wire logic [NOUT-1:0] clk_src,
   output logic [NOUT-1:0] clk_out,
   output logic [NOUT-1:0] clk_out_drive,
   output logic chip_shutdown_input,
   output logic wr_stb,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data
);
   import cgi_pkg::*;
   // ------------------------------------------------------------
   // Synchronised pins
   // ------------------------------------------------------------
   logic [2:0] pins_s; // scl, sda, control pin
   cgi_sync #(.WIDTH(3)) u_sync (
      .clk_sys(clk_sys),
      .srst(srst),
      .din({link.scl, link.sda, powerdown_or_enable_pin}),
      .dout(pins_s)
   );
   logic scl_q, sda_q; // Previous line levels
   wire scl_s = pins_s[2];
   wire sda_s = pins_s[1];
   wire ctl_s = pins_s[0];
   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire start_det = scl_s & scl_q & sda_q & ~sda_s; // RL6
   wire stop_det = scl_s & scl_q & ~sda_q & sda_s; // RL7
   // ------------------------------------------------------------
   // Power-down handling
   // ------------------------------------------------------------
   // Pin low in power-down mode
   wire pd_now = ~pin_mode_oe & ~ctl_s; // RL19
   // Without keep-alive, power-down clears the memory
   wire wipe = srst | (pd_now & ~keep_alive); // RL18 RL22
   // ------------------------------------------------------------
   // Slave state
   // ------------------------------------------------------------
   cgi_slv_state_type state;
   logic [7:0] mem [DEPTH]; // RL24
   logic [7:0] ptr; // RL13
   logic [7:0] shreg; // Shift register, receive only
   logic [3:0] bitn; // Bit count within byte, 8 = ack slot
   logic sda_drv; // Pulls data low
   logic addr_ack; // Next ack slot answers the read address
   logic [8:0] clr_idx; // Wipe walk index
   wire ack_slot = (bitn == 4'd8);
   wire [7:0] ptr_inc = ptr + 8'h01; // RL17
   wire [7:0] shin = {shreg[6:0], sda_s};
   wire id_match = (shin[7:1] == `CGI_SLAVE_ID); // RL1 RL2
   wire busy_clr = ~clr_idx[8];
   // Frames are dropped while memory is cleared; master must wait
   wire link_ok = ~pd_now & ~busy_clr;
   // ------------------------------------------------------------
   // Edge history
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      {scl_q, sda_q} <= srst ? 2'b11 : {scl_s, sda_s};
   end
   // ------------------------------------------------------------
   // Memory clear walk; one location per cycle after wipe
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (wipe) begin
         clr_idx <= 9'h000;
      end else if (busy_clr) begin
         clr_idx <= clr_idx + 9'h001;
      end
   end
   // ------------------------------------------------------------
   // Memory write port
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (busy_clr) begin
         mem[clr_idx[7:0]] <= `CGI_CFG_RESET; // RL18
      end else if (state == CGI_WDAT && scl_rise && bitn == 4'd7) begin
         mem[ptr] <= shin; // RL3 RL11
      end
   end
   // ------------------------------------------------------------
   // Protocol engine: samples on clock rise, drives on clock fall
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      wr_stb <= 1'b0;
      if (srst || pd_now) begin
         state <= CGI_IDLE;
         bitn <= 4'd0;
         sda_drv <= 1'b0;
         addr_ack <= 1'b0;
         shreg <= 8'h00;
         if (wipe) begin
            ptr <= `CGI_PTR_RESET;
         end
      end else if (!link_ok) begin
         state <= CGI_IDLE;
         sda_drv <= 1'b0;
      end else if (stop_det) begin
         state <= CGI_IDLE; // RL7
         sda_drv <= 1'b0;
      end else if (start_det) begin
         state <= CGI_DEVA; // RL6 RL15
         bitn <= 4'd0;
         sda_drv <= 1'b0;
      end else begin
         // Sample only on clock rise, so data is read while stable
         if (scl_rise && !ack_slot) begin // RL5
            shreg <= shin;
            bitn <= bitn + 4'd1;
            if (bitn == 4'd7) begin
               unique case (state)
                  CGI_DEVA: begin
                     addr_ack <= id_match & shin[0]; // RL12
                     if (!id_match) begin
                        state <= CGI_SKIP; // RL23
                     end else if (shin[0]) begin
                        state <= CGI_RDAT;
                     end else begin
                        state <= CGI_MLOC;
                     end
                  end
                  CGI_MLOC: begin
                     ptr <= shin; // RL15
                     state <= CGI_WDAT;
                  end
                  CGI_WDAT: begin
                     wr_stb <= 1'b1;
                     wr_addr <= ptr;
                     wr_data <= shin;
                     ptr <= ptr_inc; // RL11 RL13 RL17
                  end
                  default: begin
                  end
               endcase
            end
         end else if (scl_rise && ack_slot) begin
            bitn <= 4'd0;
            addr_ack <= 1'b0;
            // After a data byte the pointer moves on; nack leaves the bus
            if (state == CGI_RDAT && !addr_ack) begin
               ptr <= ptr_inc; // RL13 RL16 RL17
               if (sda_s) begin
                  state <= CGI_SKIP; // RL14
               end
            end
         end
         if (scl_fall) begin
            if (state == CGI_SKIP || state == CGI_IDLE) begin
               sda_drv <= 1'b0; // RL23
            end else if (ack_slot && (state != CGI_RDAT || addr_ack)) begin
               // Ack slot after a received byte
               sda_drv <= 1'b1; // RL8 RL14
            end else if (state == CGI_RDAT) begin
               // Byte out MSB first; released during master ack
               sda_drv <= (bitn < 4'd8) ? ~mem[ptr][3'd7 - bitn[2:0]] : 1'b0; // RL14
            end else begin
               sda_drv <= 1'b0;
            end
         end
      end
   end
   assign link.sda_s_oe = sda_drv; // RL8
   // ------------------------------------------------------------
   // Clock outputs
   // ------------------------------------------------------------
   // On unless powered down or gated by the pin
   wire [NOUT-1:0] want_on = {NOUT{~pd_now}} & ~({NOUT{pin_mode_oe & ~ctl_s}} & oe_sensitive); // RL21 RL22
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         clk_out <= '0;
         clk_out_drive <= '0;
         chip_shutdown_input <= 1'b0;
      end else begin
         chip_shutdown_input <= pd_now; // RL19
         for (int i = 0; i < NOUT; i++) begin
            if (want_on[i]) begin
               clk_out_drive[i] <= 1'b1;
               clk_out[i] <= clk_src[i];
            end else if (clk_out_drive[i]) begin
               // Drive low first, release only once low
               clk_out[i] <= 1'b0; // RL20
               clk_out_drive[i] <= clk_out[i];
            end
         end
      end
   end
endmodule : cgi_slave

// [design/cgi_sync.sv]
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs
module cgi_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta; // First stage, read only by second
   // ------------------------------------------------------------
   // Two flops; reset to released (high) bus levels
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         meta <= '1;
         dout <= '1;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule : cgi_sync

// [sim/cgi_link_asserts.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Two-wire link checker
// ------------------------------------------------------------
module cgi_link_asserts (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic scl,
   input wire logic sda,
   input wire logic scl_m_oe,
   input wire logic sda_m_oe,
   input wire logic sda_s_oe
);
   logic scl_q, sda_q; // Line levels one cycle ago
   logic first, rw; // Inside address byte; read frame
   logic [3:0] bits; // Clock rises seen in this byte
   logic [7:0] sh; // Bits sampled on rises
   logic [8:0] cnt; // Cycles since the clock last moved
   wire rise = scl & ~scl_q;
   wire start = scl & scl_q & sda_q & ~sda;
   wire stop = scl & scl_q & ~sda_q & sda;
   wire ack9 = rise & (bits == 4'h8);
   // Edge history; phase length saturates
   always_ff @(posedge clk_sys) begin
      scl_q <= srst | scl;
      sda_q <= srst | sda;
      cnt <= (srst | (scl != scl_q)) ? 9'h000 : cnt + 9'(cnt != 9'h1ff);
   end
   // Byte framing; a start reopens the address byte
   always_ff @(posedge clk_sys) begin
      if (srst | start) begin
         bits <= 4'h0;
         first <= 1'b1;
      end else if (rise) begin
         sh <= {sh[6:0], sda};
         bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
         first <= first & (bits != 4'h8);
         rw <= (first & ack9) ? sh[0] : rw;
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   property p_id_first;
      first & rise & (bits == 4'h7) |-> sh[6:0] == 7'h69;
   endproperty
   a_id_first: assert property (p_id_first) else $error("no slave id");
   property p_id_ack;
      first & ack9 & (sh[7:1] == 7'h69) |-> sda_s_oe & ~sda;
   endproperty
   a_id_ack: assert property (p_id_ack) else $error("id not acked");
   property p_wr_ack;
      ~first & ~rw & ack9 |-> sda_s_oe & ~sda_m_oe;
   endproperty
   a_wr_ack: assert property (p_wr_ack) else $error("write not acked");
   property p_rd_ack;
      ~first & rw & ack9 |-> ~sda_s_oe;
   endproperty
   a_rd_ack: assert property (p_rd_ack) else $error("slave drove read ack");
   property p_stable;
      scl & scl_q |-> $stable(sda_s_oe);
   endproperty
   a_stable: assert property (p_stable) else $error("slave data moved");
   property p_high_min;
      ~scl & scl_q |-> cnt >= 9'd59;
   endproperty
   a_high_min: assert property (p_high_min) else $error("short clock high");
   property p_low_min;
      $fell(scl_m_oe) |-> cnt >= 9'd119;
   endproperty
   a_low_min: assert property (p_low_min) else $error("short clock low");
   property p_start_hold;
      start |-> scl [*8];
   endproperty
   a_start_hold: assert property (p_start_hold) else $error("short start hold");
   property p_stop_idle;
      stop |=> (scl & sda) [*8];
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("bus busy after stop");
   // Main traffic kinds
   c_read: cover property (first & ack9 & sh[0]);
   c_burst: cover property (~first & ~rw & ack9);
   c_restart: cover property (start & ~first);
endmodule : cgi_link_asserts

// [sim/clock_gen_i2c_config_slave_tb.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bench: two ends face to face, plus a bench-driven slave
// ------------------------------------------------------------
module clock_gen_i2c_config_slave_tb;
   import cgi_pkg::*;
   logic clk_sys, srst; // Clock and reset
   logic cmd_valid, cmd_ready, rd_valid, nack_err; // Command handshake
   cgi_op_type cmd_op; // Command kind
   logic [7:0] cmd_loc, cmd_data, cmd_len, rd_data; // Command fields
   logic powerdown_or_enable_pin, pin_mode_oe, keep_alive; // Pin control
   logic [7:0] oe_sensitive, clk_src, clk_out, clk_out_drive; // Clock outputs
   logic chip_shutdown_input, wr_stb, wr_stb_b; // Status
   logic [7:0] wr_addr, wr_data, wr_addr_b, wr_data_b; // Store reports
   logic b_scl_oe, b_sda_oe, b_ack; // Bench side of second link
   int n_mismatch, checks, cyc; // Counters
   logic [7:0] rq[$]; // Bytes read back
   logic [15:0] wq[$]; // Location and byte of each store
   cgi_link_if link_a ();
   cgi_link_if link_b ();
   assign link_b.scl_m_oe = b_scl_oe;
   assign link_b.sda_m_oe = b_sda_oe;
   cgi_master cgi_master_i (.clk_sys(clk_sys), .srst(srst), .link(link_a), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_loc(cmd_loc), .cmd_data(cmd_data), .cmd_len(cmd_len), .cmd_ready(cmd_ready),
      .rd_valid(rd_valid), .rd_data(rd_data), .nack_err(nack_err));
   cgi_slave cgi_slave_i (.clk_sys(clk_sys), .srst(srst), .link(link_a),
      .powerdown_or_enable_pin(powerdown_or_enable_pin), .pin_mode_oe(pin_mode_oe), .keep_alive(keep_alive),
      .oe_sensitive(oe_sensitive), .clk_src(clk_src), .clk_out(clk_out), .clk_out_drive(clk_out_drive),
      .chip_shutdown_input(chip_shutdown_input), .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data));
   // Second slave, its far side driven by bench tasks
   cgi_slave cgi_slave_i2 (.clk_sys(clk_sys), .srst(srst), .link(link_b),
      .powerdown_or_enable_pin(powerdown_or_enable_pin), .pin_mode_oe(pin_mode_oe), .keep_alive(keep_alive),
      .oe_sensitive(oe_sensitive), .clk_src(clk_src), .clk_out(), .clk_out_drive(),
      .chip_shutdown_input(), .wr_stb(wr_stb_b), .wr_addr(wr_addr_b), .wr_data(wr_data_b));
   cgi_link_asserts cgi_link_asserts_i (.clk_sys(clk_sys), .srst(srst), .scl(link_a.scl), .sda(link_a.sda),
      .scl_m_oe(link_a.scl_m_oe), .sda_m_oe(link_a.sda_m_oe), .sda_s_oe(link_a.sda_s_oe));
   // 100 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Source clocks toggle so gating is visible
   always @(negedge clk_sys) clk_src <= ~clk_src;
   // Capture reads and stores; cut a hang short
   always @(posedge clk_sys) begin
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (wr_stb === 1'b1) wq.push_back({wr_addr, wr_data});
      cyc++;
      if (cyc == 90000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task print_verdict;
      $display("mismatches=%0d checks=%0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict
   // One command, then wait for its stop
   task automatic run_cmd(input cgi_op_type op, input logic [7:0] loc, input logic [7:0] dat, input logic [7:0] len);
      @(negedge clk_sys);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_loc = loc;
      cmd_data = dat;
      cmd_len = len;
      do @(posedge clk_sys); while (cmd_ready !== 1'b1);
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      for (int n = 0; n < 30000 && cmd_ready !== 1'b1; n++) @(negedge clk_sys);
   endtask : run_cmd
   // Read bytes must count up from e0
   task automatic chk_rd(input logic [7:0] e0, input int n);
      check(16'(rq.size()), 16'(n));
      foreach (rq[i]) check(16'(rq[i]), 16'(8'(e0 + i)));
      rq.delete();
   endtask : chk_rd
   // Stores must walk location and byte together
   task automatic chk_wr(input logic [7:0] a0, input logic [7:0] d0, input int n);
      check(16'(wq.size()), 16'(n));
      foreach (wq[i]) check(wq[i], {8'(a0 + i), 8'(d0 + i)});
      wq.delete();
   endtask : chk_wr
   // One bit on the bench link, 160 ns per clock
   task automatic raw_bit(input logic v);
      repeat (4) @(negedge clk_sys);
      b_sda_oe = ~v;
      repeat (4) @(negedge clk_sys);
      b_scl_oe = 1'b0;
      repeat (7) @(negedge clk_sys);
      b_ack = link_b.sda;
      @(negedge clk_sys);
      b_scl_oe = 1'b1;
   endtask : raw_bit
   task automatic raw_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) raw_bit(b[i]);
      raw_bit(1'b1);
   endtask : raw_byte
   // Start and stop: data moves while the clock is high
   task automatic raw_frame(input logic go);
      repeat (4) @(negedge clk_sys);
      b_sda_oe = go ? 1'b0 : 1'b1;
      repeat (4) @(negedge clk_sys);
      b_scl_oe = 1'b0;
      repeat (8) @(negedge clk_sys);
      b_sda_oe = go;
      repeat (8) @(negedge clk_sys);
      b_scl_oe = go;
   endtask : raw_frame
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      srst = 1'b1;
      {cmd_valid, cmd_loc, cmd_data, cmd_len, b_scl_oe, b_sda_oe} = '0;
      cmd_op = CGI_OP_WRITE;
      {powerdown_or_enable_pin, pin_mode_oe, keep_alive} = 3'b101;
      oe_sensitive = 8'h00;
      clk_src = 8'h55;
      {n_mismatch, checks, cyc} = '0;
      repeat (16) @(negedge clk_sys);
      srst = 1'b0;
      repeat (300) @(negedge clk_sys);
      check(16'(clk_out_drive), 16'h00ff);
      run_cmd(CGI_OP_WRITE, 8'hfe, 8'ha0, 8'h03);
      chk_wr(8'hfe, 8'ha0, 3);
      run_cmd(CGI_OP_READ_RND, 8'hfe, 8'h00, 8'h03);
      chk_rd(8'ha0, 3);
      check(16'(wq.size()), 16'h0000);
      check(16'(nack_err), 16'h0000);
      run_cmd(CGI_OP_WRITE, 8'h20, 8'h33, 8'h02);
      run_cmd(CGI_OP_SET_PTR, 8'h20, 8'h00, 8'h01);
      chk_wr(8'h20, 8'h33, 2);
      run_cmd(CGI_OP_READ_CUR, 8'h00, 8'h00, 8'h01);
      chk_rd(8'h33, 1);
      run_cmd(CGI_OP_READ_CUR, 8'h00, 8'h00, 8'h01);
      chk_rd(8'h34, 1);
      // Power-down with keep-alive, then without
      for (int k = 1; k >= 0; k--) begin
         keep_alive = k[0];
         powerdown_or_enable_pin = 1'b0;
         repeat (20) @(negedge clk_sys);
         check(16'(chip_shutdown_input), 16'h0001);
         check(16'(clk_out_drive), 16'h0000);
         powerdown_or_enable_pin = 1'b1;
         repeat (300) @(negedge clk_sys);
         run_cmd(CGI_OP_READ_RND, 8'h20, 8'h00, 8'h01);
         chk_rd(k ? 8'h33 : 8'h00, 1);
      end
      check(16'(chip_shutdown_input), 16'h0000);
      // Output-enable mode gates only sensitive outputs
      pin_mode_oe = 1'b1;
      oe_sensitive = 8'h0f;
      powerdown_or_enable_pin = 1'b0;
      repeat (20) @(negedge clk_sys);
      check(16'(clk_out_drive), 16'h00f0);
      check(16'(clk_out & 8'h0f), 16'h0000);
      powerdown_or_enable_pin = 1'b1;
      repeat (20) @(negedge clk_sys);
      check(16'(clk_out_drive), 16'h00ff);
      // Foreign id: no answer, rest ignored
      raw_frame(1'b1);
      raw_byte(8'hd0);
      check(16'(b_ack), 16'h0001);
      raw_byte(8'h00);
      check(16'(b_ack), 16'h0001);
      raw_frame(1'b0);
      raw_frame(1'b1);
      raw_byte(8'hd2);
      check(16'(b_ack), 16'h0000);
      raw_byte(8'h05);
      check(16'(b_ack), 16'h0000);
      raw_byte(8'hc3);
      check(16'(b_ack), 16'h0000);
      raw_frame(1'b0);
      check({wr_addr_b, wr_data_b}, 16'h05c3);
      print_verdict();
   end
endmodule : clock_gen_i2c_config_slave_tb
